// File: logic/csi_defines.vh
// Constants for the core system interface control block.
// Assumes a single 100 MHz clock and an APB register port with 32-bit data.
`ifndef CSI_DEFINES_VH
`define CSI_DEFINES_VH

// Register byte offsets
`define CSI_OFS_STATUS   8'h00
`define CSI_OFS_THIRD_CONFIGURATION_REGISTER  8'h04
`define CSI_OFS_CONTROL  8'h08
`define CSI_OFS_EVENT    8'h0c

// Status fields
`define CSI_ST_IE        0
`define CSI_ST_EXL       1
`define CSI_ST_ERL       2
`define CSI_ST_SR        20
`define CSI_ST_RP        27

// Third configuration register field
`define CSI_CF_EXT_CONTROLLER_FLAG      6

// Control fields, write-only pulses
`define CSI_CT_EXC       0
`define CSI_CT_WAIT      1
`define CSI_CT_DRET      2

// Event register fields
`define CSI_EV_SET_LSB   0
`define CSI_EV_VEC_LSB   4
`define CSI_EV_DBG       16
`define CSI_EV_NMI       17

// Reset values
`define CSI_ST_RESET     32'h0000_0004

// Reference clock divider: half period in core cycles
`define CSI_REF_HALF     4'h1

`endif

// File: logic/csi_sync.v
// Two-flop synchroniser, one per bit.
// Assumes inputs may change at any time relative to clk.
module csi_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            // First stage feeds only the second stage
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta   <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta   <= async_in[i];
                    stable <= meta;
                end
            end
            assign sync_out[i] = stable;
        end
    endgenerate

endmodule

// File: logic/csi_edge.v
// Rising-edge detector, one per bit, on already synchronised levels.
// Assumes inputs are synchronous to clk.
module csi_edge #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] rise_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg last;
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    last <= 1'b0;
                end else begin
                    last <= level_in[i];
                end
            end
            // High only on a low sample followed by a high sample
            assign rise_out[i] = level_in[i] & ~last;
        end
    endgenerate

endmodule

// File: logic/csi_ctl.v
// Core system interface control: resets, NMI, debug interrupt, status bits,
// sleep, interrupt acknowledge and shadow set capture, reached over APB.
// Assumes one clock, asynchronous active-low rstn, and an external
// interrupt controller driving vector and shadow set synchronously.
`include "csi_defines.vh"

module csi_ctl #(
    parameter VEC_W = 6,
    parameter SET_W = 4
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire             cold_reset_in,
    input  wire             warm_reset_in,
    input  wire             nmi_in,
    input  wire             debug_interrupt_in,
    input  wire             test_port_reset_n,
    input  wire             ext_irq_ctrl_present_in,
    input  wire [VEC_W-1:0] irq_vector_in,
    input  wire [SET_W-1:0] irq_shadow_set_in,
    output reg              bus_reference_clock_out,
    output reg              error_level_out,
    output reg              exception_level_out,
    output reg              reduced_power_out,
    output reg              sleep_out,
    output reg              irq_acknowledge_out,
    output reg  [SET_W-1:0] active_shadow_set_out,
    output reg              debug_mode_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and edge detection

    wire [4:0] async_raw;
    wire [4:0] async_s;
    wire [1:0] edge_rise;
    wire       cold_s;
    wire       warm_s;
    wire       nmi_s;
    wire       dint_s;
    wire       trst_n_s;
    wire       reset_any;
    wire       nmi_rise;
    wire       dint_rise;

    // Inverted so its synchroniser resets to the pin's idle level
    // Test reset is the only active-low pin of the five synchronised here
    assign async_raw = {~test_port_reset_n, debug_interrupt_in, nmi_in, warm_reset_in, cold_reset_in};

    csi_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (async_raw),
        .sync_out (async_s)
    );

    assign cold_s   = async_s[0];
    assign warm_s   = async_s[1];
    assign nmi_s    = async_s[2];
    assign dint_s   = async_s[3];
    assign trst_n_s = ~async_s[4];

    // Warm reset is folded into cold reset for internal use
    assign reset_any = cold_s | warm_s;

    csi_edge #(
        .WIDTH (2)
    ) u_edge (
        .clk      (clk),
        .rstn     (rstn),
        .level_in ({dint_s, nmi_s}),
        .rise_out (edge_rise)
    );

    // One NMI per low-to-high transition, however long held
    assign nmi_rise  = edge_rise[0];
    // Debug edges are ignored while the test reset is low
    assign dint_rise = edge_rise[1] & trst_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronous input sampling

    reg [VEC_W-1:0] vec_q;
    reg [SET_W-1:0] set_q;
    reg             eic_present;

    // No synchroniser here: an encoded vector must land whole in one cycle
    // Vector and shadow set are sampled together each rising edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vec_q <= {VEC_W{1'b0}};
            set_q <= {SET_W{1'b0}};
        end else begin
            vec_q <= irq_vector_in;
            set_q <= irq_shadow_set_in;
        end
    end

    // Limitation: the flag reads 0 until a cold reset has been seen
    // Static strap is caught only while cold reset holds
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eic_present <= 1'b0;
        end else if (cold_s) begin
            eic_present <= ext_irq_ctrl_present_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, response from flops

    wire        acc;
    wire        wr_en;
    wire        hit_status;
    wire        hit_config;
    wire        hit_control;
    wire        hit_event;
    wire        mapped;

    assign acc         = psel & penable & pready;
    assign wr_en       = acc & pwrite;
    assign hit_status  = (paddr == `CSI_OFS_STATUS);
    assign hit_config  = (paddr == `CSI_OFS_THIRD_CONFIGURATION_REGISTER);
    assign hit_control = (paddr == `CSI_OFS_CONTROL);
    assign hit_event   = (paddr == `CSI_OFS_EVENT);
    assign mapped      = hit_status | hit_config | hit_control | hit_event;

    ////////////////////////////////////////////////////////////////////////////
    // Exception and interrupt decisions

    reg         ie;
    reg         soft_reset_flag;
    reg         dbg_seen;
    reg         nmi_seen;
    reg  [VEC_W-1:0] vec_taken;
    wire        irq_pending;
    wire        irq_take;
    wire        sw_exc;
    wire        sw_wait;
    wire        sw_dret;

    assign sw_exc  = wr_en & hit_control & pwdata[`CSI_CT_EXC];
    assign sw_wait = wr_en & hit_control & pwdata[`CSI_CT_WAIT];
    assign sw_dret = wr_en & hit_control & pwdata[`CSI_CT_DRET];

    assign irq_pending = |vec_q;
    // Blocked at error or exception level, in debug, or under reset
    // An NMI edge in the same cycle wins over the interrupt
    assign irq_take = irq_pending & ie & ~exception_level_out & ~error_level_out
                    & ~debug_mode_out & ~reset_any & ~nmi_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Next status values: software write first, hardware events win

    reg next_ie;
    reg next_exl;
    reg next_erl;
    reg next_rp;
    reg next_sr;

    always @* begin
        next_ie  = ie;
        next_exl = exception_level_out;
        next_erl = error_level_out;
        next_rp  = reduced_power_out;
        next_sr  = soft_reset_flag;
        if (wr_en && hit_status) begin
            next_ie  = pwdata[`CSI_ST_IE];
            next_exl = pwdata[`CSI_ST_EXL];
            next_erl = pwdata[`CSI_ST_ERL];
            next_rp  = pwdata[`CSI_ST_RP];
            next_sr  = pwdata[`CSI_ST_SR];
        end
        if (irq_take || sw_exc) begin
            next_exl = 1'b1;
            next_ie  = 1'b0;
        end
        if (nmi_rise) begin
            next_erl = 1'b1;
        end
        // Last, so no write can leave error level while a reset pin is high
        if (reset_any) begin
            // Reset exception from either reset pin
            next_erl = 1'b1;
            next_exl = 1'b0;
            next_ie  = 1'b0;
            next_rp  = 1'b0;
            next_sr  = warm_s & ~cold_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status register; outputs are the status flops themselves

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ie                  <= 1'b0;
            exception_level_out <= 1'b0;
            error_level_out     <= 1'b1;
            reduced_power_out   <= 1'b0;
            soft_reset_flag     <= 1'b0;
        end else begin
            ie                  <= next_ie;
            exception_level_out <= next_exl;
            error_level_out     <= next_erl;
            reduced_power_out   <= next_rp;
            soft_reset_flag     <= next_sr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt acknowledge, shadow set and captured vector

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_acknowledge_out   <= 1'b0;
            active_shadow_set_out <= {SET_W{1'b0}};
            vec_taken             <= {VEC_W{1'b0}};
        end else begin
            // EXCEPTION_LEVEL_BIT rises with the pulse, so it cannot repeat
            irq_acknowledge_out <= irq_take;
            if (irq_take) begin
                active_shadow_set_out <= set_q;
                vec_taken             <= vec_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep and debug mode

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_out <= 1'b0;
        end else if (reset_any || nmi_rise || dint_rise || irq_pending) begin
            // Any interrupt ends the wait, even a masked one
            sleep_out <= 1'b0;
        end else if (sw_wait) begin
            sleep_out <= 1'b1;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            debug_mode_out <= 1'b0;
        end else if (reset_any || !trst_n_s) begin
            // Test reset outranks a debug edge in the same cycle
            debug_mode_out <= 1'b0;
        end else if (dint_rise) begin
            debug_mode_out <= 1'b1;
        end else if (sw_dret) begin
            debug_mode_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event flags: a new event wins over a write-one clear
    // A second event before the clear is seen only once

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dbg_seen <= 1'b0;
            nmi_seen <= 1'b0;
        end else begin
            if (dint_rise) begin
                dbg_seen <= 1'b1;
            end else if (wr_en && hit_event && pwdata[`CSI_EV_DBG]) begin
                dbg_seen <= 1'b0;
            end
            if (nmi_rise) begin
                nmi_seen <= 1'b1;
            end else if (wr_en && hit_event && pwdata[`CSI_EV_NMI]) begin
                nmi_seen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    reg [31:0] rd_val;

    always @* begin
        rd_val = 32'h0000_0000;
        if (hit_status) begin
            rd_val[`CSI_ST_IE]  = ie;
            rd_val[`CSI_ST_EXL] = exception_level_out;
            rd_val[`CSI_ST_ERL] = error_level_out;
            rd_val[`CSI_ST_SR]  = soft_reset_flag;
            rd_val[`CSI_ST_RP]  = reduced_power_out;
        end else if (hit_config) begin
            rd_val[`CSI_CF_EXT_CONTROLLER_FLAG] = eic_present;
        end else if (hit_event) begin
            rd_val[`CSI_EV_SET_LSB +: SET_W] = active_shadow_set_out;
            rd_val[`CSI_EV_VEC_LSB +: VEC_W] = vec_taken;
            rd_val[`CSI_EV_DBG]              = dbg_seen;
            rd_val[`CSI_EV_NMI]              = nmi_seen;
        end
    end

    // Ready rises in the second access cycle; data and error ride with it
    // Ready drops after one cycle, so a held access cannot complete in two cycles in a row
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rd_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus reference clock: flop-driven so its skew matches other outputs,
    // at the cost of running below the core rate

    reg [3:0] ref_cnt;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt                 <= 4'h0;
            bus_reference_clock_out <= 1'b0;
        end else if (ref_cnt == `CSI_REF_HALF - 4'h1) begin
            ref_cnt                 <= 4'h0;
            bus_reference_clock_out <= ~bus_reference_clock_out;
        end else begin
            ref_cnt <= ref_cnt + 4'h1;
        end
    end

endmodule

// File: sim/csi_ctl_props.sv
// Concurrent checks on the pins of the system interface control block.
// Assumes one clock domain with rstn active low; bound to every csi_ctl.
module csi_ctl_props #(
    parameter VEC_W = 6,
    parameter SET_W = 4
) (
    input logic             clk,
    input logic             rstn,
    input logic             psel,
    input logic             penable,
    input logic             pwrite,
    input logic [7:0]       paddr,
    input logic [31:0]      pwdata,
    input logic             pready,
    input logic             cold_reset_in,
    input logic             warm_reset_in,
    input logic             nmi_in,
    input logic             debug_interrupt_in,
    input logic             test_port_reset_n,
    input logic [VEC_W-1:0] irq_vector_in,
    input logic [SET_W-1:0] irq_shadow_set_in,
    input logic             bus_reference_clock_out,
    input logic             error_level_out,
    input logic             exception_level_out,
    input logic             reduced_power_out,
    input logic             sleep_out,
    input logic             irq_acknowledge_out,
    input logic [SET_W-1:0] active_shadow_set_out,
    input logic             debug_mode_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    a_ack_width: assert property (irq_acknowledge_out |=> !irq_acknowledge_out)
        else $error("ack longer than one cycle");
    a_ack_exl: assert property (irq_acknowledge_out |-> exception_level_out)
        else $error("exception level low at ack");
    a_ack_set: assert property (irq_acknowledge_out |-> active_shadow_set_out == $past(irq_shadow_set_in, 2))
        else $error("shadow set not captured with vector");
    a_nmi_edge: assert property ($rose(nmi_in) && !error_level_out |-> ##[2:4] error_level_out)
        else $error("nmi edge did not raise error level");
    a_debug_edge: assert property ($rose(debug_interrupt_in) && test_port_reset_n && !debug_mode_out
        |-> ##[2:4] debug_mode_out)
        else $error("debug edge did not enter debug mode");
    a_cold_state: assert property (cold_reset_in [*4] |-> error_level_out && !exception_level_out && !sleep_out)
        else $error("cold reset state wrong");
    a_warm_erl: assert property (warm_reset_in [*4] |-> error_level_out)
        else $error("warm reset did not raise error level");
    a_test_reset: assert property (!test_port_reset_n [*4] |-> !debug_mode_out)
        else $error("debug mode survives test reset");
    a_sleep_wake: assert property (sleep_out && irq_vector_in != 0 |-> ##[1:4] !sleep_out)
        else $error("sleep not left on request");
    a_ref_clock: assert property ($past(rstn) |=> bus_reference_clock_out != $past(bus_reference_clock_out))
        else $error("reference clock stalled");
    a_rp_mirror: assert property (psel && penable && pready && pwrite && paddr == 8'h00
        |=> reduced_power_out == $past(pwdata[27]))
        else $error("reduced power pin differs from status");
    a_apb_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("apb answer late");
endmodule

bind csi_ctl csi_ctl_props #(.VEC_W(VEC_W), .SET_W(SET_W)) csi_ctl_props_inst (.*);

// File: sim/csi_sys_model.sv
// External interrupt controller and strap logic facing the block.
// Assumes a one-cycle go pulse; lag sets how slowly the request appears.
module csi_sys_model (
    input  logic       clk,
    input  logic       go,
    input  logic [3:0] lag,
    input  logic [5:0] want_vec,
    input  logic [3:0] want_set,
    input  logic       irq_acknowledge_out,
    output logic       ext_irq_ctrl_present_in,
    output logic [5:0] irq_vector_in,
    output logic [3:0] irq_shadow_set_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    logic       armed = 1'b0;
    initial irq_vector_in = 6'h00;
    initial irq_shadow_set_in = 4'h0;
    // Strap never moves outside reset
    assign ext_irq_ctrl_present_in = 1'b1;
    // Vector and set change together on the core edge
    always @(posedge clk) begin
        if (go) begin
            armed <= 1'b1;
            cnt <= lag;
        end else if (armed && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (armed) begin
            armed <= 1'b0;
            irq_vector_in <= want_vec;
            irq_shadow_set_in <= want_set;
        end
        // Serviced: withdraw; set shows no stale value
        if (irq_acknowledge_out) begin
            irq_vector_in <= 6'h00;
            irq_shadow_set_in <= ~irq_shadow_set_in;
        end
    end
endmodule

// File: sim/csi_ctl_test.sv
// Self-checking bench for csi_ctl with an APB master task.
// Assumes cold reset is applied at start; the APB master waits for pready.
module csi_ctl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, go, er;
    logic        cold_reset_in, warm_reset_in, nmi_in, debug_interrupt_in, test_port_reset_n;
    logic        ext_irq_ctrl_present_in, bus_reference_clock_out, error_level_out, debug_mode_out;
    logic        exception_level_out, reduced_power_out, sleep_out, irq_acknowledge_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  irq_vector_in, want_vec;
    logic [3:0]  irq_shadow_set_in, active_shadow_set_out, want_set, lag;
    int          failures, checks_done, n;

    csi_ctl csi_ctl_inst (.*);
    csi_sys_model csi_sys_model_inst (.*);
    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Idle edge first, so psel is never written twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        // Ready is judged only at rising edges; the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task give(input logic [5:0] v, input logic [3:0] s, input logic [3:0] l);
        @(posedge clk);
        want_vec <= v;
        want_set <= s;
        lag <= l;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        @(negedge clk);
        chk("erl pin", 1, error_level_out);
        chk("quiet pins", 0, {exception_level_out, sleep_out, irq_acknowledge_out});
        rd = {31'h0, ~bus_reference_clock_out};
        @(negedge clk) chk("ref toggle", rd, bus_reference_clock_out);
        apb(0, 8'h00, 0);
        chk("status", 32'h4, rd);
        apb(0, 8'h04, 0);
        chk("third_configuration_register", 32'h40, rd);
        apb(0, 8'h10, 0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        $display("test reset done");
    endtask

    task t_irq;
        apb(1, 8'h00, 32'h1);
        @(negedge clk) chk("erl off", 0, error_level_out);
        give(6'h05, 4'h3, 4'h2);
        n = 0;
        while (irq_acknowledge_out !== 1'b1 && n < 40) begin @(negedge clk); n++; end
        chk("shadow set", 3, active_shadow_set_out);
        chk("exl pin", 1, exception_level_out);
        @(negedge clk) chk("ack width", 0, irq_acknowledge_out);
        apb(0, 8'h0c, 0);
        chk("event", 32'h53, rd);
        $display("test irq done");
    endtask

    task t_sleep;
        apb(1, 8'h00, 32'h0800_0000);
        @(negedge clk) chk("rp pin", 1, reduced_power_out);
        chk("exl written", 0, exception_level_out);
        apb(1, 8'h08, 32'h2);
        repeat (3) @(negedge clk);
        chk("sleep", 1, sleep_out);
        give(6'h07, 4'h1, 4'h0);
        repeat (6) @(negedge clk);
        chk("woken", 0, sleep_out);
        chk("masked", 0, exception_level_out);
        give(6'h00, 4'h0, 4'h0);
        apb(1, 8'h08, 32'h1);
        @(negedge clk) chk("sw exception", 1, exception_level_out);
        $display("test sleep done");
    endtask

    // Inputs stay high long after the edge: only one event each
    task t_events;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            if (i == 0) nmi_in <= 1'b1;
            else debug_interrupt_in <= 1'b1;
            repeat (12) @(negedge clk);
            chk("event level", 1, i ? debug_mode_out : error_level_out);
            apb(0, 8'h0c, 0);
            chk("seen flag", 1, rd[17-i]);
            apb(1, 8'h0c, 32'h1 << (17 - i));
            apb(0, 8'h0c, 0);
            chk("single event", 0, rd[17-i]);
        end
        apb(1, 8'h08, 32'h4);
        @(negedge clk) chk("debug left", 0, debug_mode_out);
        @(posedge clk) debug_interrupt_in <= 1'b0;
        repeat (4) @(posedge clk);
        debug_interrupt_in <= 1'b1;
        repeat (6) @(negedge clk);
        chk("debug again", 1, debug_mode_out);
        @(posedge clk) test_port_reset_n <= 1'b0;
        repeat (6) @(negedge clk);
        chk("debug cleared", 0, debug_mode_out);
        @(posedge clk);
        nmi_in <= 1'b0;
        debug_interrupt_in <= 1'b0;
        @(posedge clk) test_port_reset_n <= 1'b1;
        $display("test events done");
    endtask

    task t_resets;
        @(posedge clk) warm_reset_in <= 1'b1;
        repeat (6) @(negedge clk);
        apb(0, 8'h00, 0);
        chk("soft reset", 32'h0010_0004, rd & 32'h0010_0004);
        @(posedge clk) cold_reset_in <= 1'b1;
        repeat (6) @(negedge clk);
        apb(0, 8'h00, 0);
        chk("cold over warm", 32'h4, rd & 32'h0010_0004);
        @(posedge clk);
        cold_reset_in <= 1'b0;
        warm_reset_in <= 1'b0;
        $display("test resets done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        stop_test;
    end

    initial begin
        {rstn, psel, penable, pwrite, go, warm_reset_in, nmi_in, debug_interrupt_in} = 8'h00;
        {paddr, pwdata, want_vec, want_set, lag} = 54'h0;
        cold_reset_in = 1'b1;
        test_port_reset_n = 1'b1;
        failures = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        cold_reset_in <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset;
        t_irq;
        t_sleep;
        t_events;
        t_resets;
        stop_test;
    end
endmodule
